// ==== rtl/umc_modem_ctrl.sv ====
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Modem handshake control with diagnostic loopback
// ------------------------------------------------------------------
//
// Behaviour
// R1 - Control bit 4 set enters loopback; clearing it restores normal work.
// R2 - In loopback the serial data output stays at mark, logic 1.
// R3 - In loopback receive ignores the pin and takes the transmit shifter.
// R4 - In loopback external CTS, DSR, RI and DCD pins are disconnected.
// R5 - Loopback feeds ready to DSR, request to CTS, spare to RI, enable to DCD.
// R6 - In loopback all modem output pins sit inactive high.
// R7 - Receive and transmit interrupts keep working in loopback.
// R8 - In loopback modem events come from control bits 3 to 0.
// R9 - Bit 3 clear floats the interrupt pin; set drives it.
// R10 - Bit 2 is a software flag with no pin; feeds RI in loopback.
// R11 - Active-low request-to-send pin follows bit 1 inverted.
// R12 - Active-low terminal-ready pin is low when bit 0 is 1.
// R13 - Reset clears control bits; bits 7 to 5 read zero, ignore writes.
module umc_modem_ctrl
   import umc_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // AXI4-Lite write address and data
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // AXI4-Lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic      [1:0]  s_axi_bresp,
   // AXI4-Lite read
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic      [31:0] s_axi_rdata,
   output logic      [1:0]  s_axi_rresp,
   // Shifter side, same clock
   input  wire logic        txShiftOut,
   output logic             rxShiftIn,
   input  wire logic        rxTxIntReq,
   // Serial and modem pins
   output logic             txdPin,
   input  wire logic        rxdPin,
   output logic             termReadyN,
   output logic             reqSendN,
   input  wire logic        clearSendN,
   input  wire logic        setReadyN,
   input  wire logic        ringN,
   input  wire logic        carrierN,
   // Serial port interrupt pin, enable low while driven
   output logic             irqPinOut,
   output logic             irqPinOeN,
   // Modem event interrupt
   output logic             irq
);
   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [CTL_W-1:0] hsCtl;
   logic [3:0]       evtStatus;
   logic [3:0]       evtMask;
   logic [4:0]       pinSync;
   logic [LN_W-1:0]  modemLines;
   logic [LN_W-1:0]  lineChange;
   logic             loopback;
   logic             awGot;
   logic             wGot;
   logic [7:0]       awAddrQ;
   logic [31:0]      wDataQ;
   logic             wStrb0;
   logic             doWrite;
   logic [31:0]      next_rdata;
   logic [1:0]       next_rresp;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   assign loopback = hsCtl[LOOP_BIT];   // [R1]
   assign doWrite  = awGot && wGot && !s_axi_bvalid;

   // ---------------------------------------------------------------
   // Pin synchroniser and change detector
   // ---------------------------------------------------------------
   umc_sync u_sync (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .pinIn   ({carrierN, ringN, setReadyN, clearSendN, rxdPin}),
      .pinSync (pinSync)
   );

   // Pins are cut off in loopback; control bits stand in for them
   always_comb
   begin
      if (loopback)   // [R4]
      begin
         modemLines[LN_DSR] = hsCtl[TERM_RDY_BIT];   // [R5]
         modemLines[LN_CTS] = hsCtl[REQ_SEND_BIT];   // [R5]
         modemLines[LN_RI]  = hsCtl[SPARE_BIT];      // [R10]
         modemLines[LN_DCD] = hsCtl[IRQ_EN_BIT];     // [R5]
      end
      else
         modemLines = ~pinSync[4:1];
   end

   umc_delta u_delta (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .lines   (modemLines),
      .change  (lineChange)   // [R8]
   );

   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   // Address and data taken in either order, answered when both held
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         awGot         <= 1'b0;
         wGot          <= 1'b0;
         awAddrQ       <= 8'h00;
         wDataQ        <= 32'h0000_0000;
         wStrb0        <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awGot         <= 1'b1;
            awAddrQ       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         else if (!awGot && !s_axi_awready)
            s_axi_awready <= 1'b1;
         if (s_axi_wvalid && s_axi_wready)
         begin
            wGot         <= 1'b1;
            wDataQ       <= s_axi_wdata;
            wStrb0       <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         else if (!wGot && !s_axi_wready)
            s_axi_wready <= 1'b1;
         if (doWrite)
         begin
            s_axi_bvalid <= 1'b1;
            if (hit(awAddrQ, HSCTL_OFF) || hit(awAddrQ, LINES_OFF) ||
                hit(awAddrQ, EVT_OFF) || hit(awAddrQ, MASK_OFF))
               s_axi_bresp <= RESP_OKAY;
            else
               s_axi_bresp <= RESP_DECERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            awGot        <= 1'b0;
            wGot         <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // Control register; only the low five bits exist
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         hsCtl <= CTL_RESET;   // [R13]
      else if (doWrite && wStrb0 && hit(awAddrQ, HSCTL_OFF))
         hsCtl <= wDataQ[CTL_W-1:0];   // [R13]
   end

   // Mask register gates events onto irq
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         evtMask <= MASK_RESET;
      else if (doWrite && wStrb0 && hit(awAddrQ, MASK_OFF))
         evtMask <= wDataQ[3:0];
   end

   // Sticky events, write one to clear; a new event beats the clear
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         evtStatus <= EVT_RESET;
      else if (doWrite && wStrb0 && hit(awAddrQ, EVT_OFF))
         evtStatus <= (evtStatus & ~wDataQ[3:0]) | lineChange;   // [R8]
      else
         evtStatus <= evtStatus | lineChange;   // [R8]
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      next_rresp = RESP_OKAY;
      if (hit(s_axi_araddr, HSCTL_OFF))
         next_rdata[CTL_W-1:0] = hsCtl;   // [R13]
      else if (hit(s_axi_araddr, LINES_OFF))
         next_rdata[LN_W-1:0] = modemLines;
      else if (hit(s_axi_araddr, EVT_OFF))
         next_rdata[3:0] = evtStatus;
      else if (hit(s_axi_araddr, MASK_OFF))
         next_rdata[3:0] = evtMask;
      else
         next_rresp = RESP_DECERR;
   end

   // One read at a time; data answered the edge after the address
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
      else if (!s_axi_rvalid && !s_axi_arready)
         s_axi_arready <= 1'b1;
   end

   // ---------------------------------------------------------------
   // Serial data path
   // ---------------------------------------------------------------
   // Registered so pins never glitch while loopback toggles
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         txdPin    <= 1'b1;
         rxShiftIn <= 1'b1;
      end
      else if (loopback)
      begin
         txdPin    <= 1'b1;         // [R2]
         rxShiftIn <= txShiftOut;   // [R3]
      end
      else
      begin
         txdPin    <= txShiftOut;
         rxShiftIn <= pinSync[0];
      end
   end

   // ---------------------------------------------------------------
   // Modem outputs and interrupts
   // ---------------------------------------------------------------
   // Handshake pins inverted from the bits, parked high in loopback
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         termReadyN <= 1'b1;
         reqSendN   <= 1'b1;
      end
      else
      begin
         termReadyN <= loopback | ~hsCtl[TERM_RDY_BIT];   // [R6] [R12]
         reqSendN   <= loopback | ~hsCtl[REQ_SEND_BIT];   // [R6] [R11]
      end
   end

   // Pin carries the shifter request plus modem events alike
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         irq       <= 1'b0;
         irqPinOut <= 1'b0;
         irqPinOeN <= 1'b1;
      end
      else
      begin
         irq       <= |(evtStatus & evtMask);
         irqPinOut <= rxTxIntReq | (|(evtStatus & evtMask));   // [R7]
         irqPinOeN <= ~hsCtl[IRQ_EN_BIT];   // [R9]
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   a_loop_enter: assert property (   // [R1]
      doWrite && wStrb0 && hit(awAddrQ, HSCTL_OFF) && wDataQ[LOOP_BIT]
      |=> loopback)
      else $error("loopback not entered");
   a_txd_mark: assert property (loopback |=> txdPin)   // [R2]
      else $error("txd not at mark in loopback");
   a_rx_route: assert property (   // [R3]
      loopback |=> rxShiftIn == $past(txShiftOut))
      else $error("receive not fed from transmit");
   a_lines_fed: assert property (   // [R5]
      loopback && s_axi_arvalid && s_axi_arready &&
      hit(s_axi_araddr, LINES_OFF)
      |=> s_axi_rdata[LN_W-1:0] == {$past(hsCtl[IRQ_EN_BIT]),
          $past(hsCtl[SPARE_BIT]), $past(hsCtl[TERM_RDY_BIT]),
          $past(hsCtl[REQ_SEND_BIT])})
      else $error("loopback lines wrong");
   a_pins_idle: assert property (   // [R6]
      loopback |=> termReadyN && reqSendN)
      else $error("modem pins active in loopback");
   a_irq_pass: assert property (   // [R7]
      rxTxIntReq |=> irqPinOut)
      else $error("shifter interrupt lost");
   a_loop_event: assert property (   // [R8]
      loopback && $past(loopback) && $changed(hsCtl[REQ_SEND_BIT])
      |=> evtStatus[LN_CTS])
      else $error("loopback change gave no event");
   a_irq_float: assert property (   // [R9]
      !hsCtl[IRQ_EN_BIT] |=> irqPinOeN)
      else $error("irq pin driven while disabled");
   a_rts_drive: assert property (   // [R11]
      !loopback |=> reqSendN == !$past(hsCtl[REQ_SEND_BIT]))
      else $error("request pin wrong");
   a_dtr_drive: assert property (   // [R12]
      !loopback |=> termReadyN == !$past(hsCtl[TERM_RDY_BIT]))
      else $error("ready pin wrong");
   a_resv_zero: assert property (   // [R13]
      s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, HSCTL_OFF)
      |=> s_axi_rdata[31:CTL_W] == 27'h0)
      else $error("reserved bits not zero");

   c_loop_on: cover property (!loopback ##1 loopback);
   c_evt_irq: cover property (!irq ##1 irq);
   c_write_rsp: cover property (s_axi_bvalid && s_axi_bready);
endmodule

// ==== rtl/umc_pkg.sv ====
package umc_pkg;
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] HSCTL_OFF = 8'h04;   // modem_handshake_control
   localparam logic [7:0] LINES_OFF = 8'h08;   // present modem line state
   localparam logic [7:0] EVT_OFF   = 8'h0C;   // sticky change events
   localparam logic [7:0] MASK_OFF  = 8'h10;   // event interrupt mask

   // ---------------------------------------------------------------
   // Control field positions and reset values
   // ---------------------------------------------------------------
   localparam int         CTL_W         = 5;
   localparam int         TERM_RDY_BIT  = 0;
   localparam int         REQ_SEND_BIT  = 1;
   localparam int         SPARE_BIT     = 2;
   localparam int         IRQ_EN_BIT    = 3;
   localparam int         LOOP_BIT      = 4;
   localparam logic [4:0] CTL_RESET     = 5'h00;

   // Internal modem line positions (active high inside the block)
   localparam int         LN_W      = 4;
   localparam int         LN_CTS    = 0;
   localparam int         LN_DSR    = 1;
   localparam int         LN_RI     = 2;
   localparam int         LN_DCD    = 3;
   localparam logic [3:0] LN_RESET  = 4'h0;
   localparam logic [3:0] EVT_RESET = 4'h0;
   localparam logic [3:0] MASK_RESET = 4'h0;

   // Pin synchroniser idle value: serial mark, handshakes inactive
   localparam logic [4:0] PIN_IDLE  = 5'h1F;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// ==== rtl/umc_sync.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Two-stage synchroniser for asynchronous pins
// ------------------------------------------------------------------
module umc_sync
   import umc_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   // Pins in, synchronised copy out
   input  wire logic [4:0] pinIn,
   output logic      [4:0] pinSync
);
   logic [4:0] stage1;

   // First stage feeds only the second; idle level at reset
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         stage1  <= PIN_IDLE;
         pinSync <= PIN_IDLE;
      end
      else
      begin
         stage1  <= pinIn;
         pinSync <= stage1;
      end
   end
endmodule

// ==== rtl/umc_delta.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Modem line change detector
// ------------------------------------------------------------------
module umc_delta
   import umc_pkg::*;
(
   // Clock and reset
   input  wire logic            ref_clk,
   input  wire logic            nrst,
   // Present lines and change pulses
   input  wire logic [LN_W-1:0] lines,
   output logic      [LN_W-1:0] change
);
   logic [LN_W-1:0] prevLines;

   // Remember last sample of the lines
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         prevLines <= LN_RESET;
      else
         prevLines <= lines;
   end

   // Ring counts only its trailing edge, the others any edge
   always_comb
   begin
      change         = lines ^ prevLines;
      change[LN_RI]  = prevLines[LN_RI] & ~lines[LN_RI];
   end
endmodule

// ==== bench/umc_modem_model.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Modem or terminal on the far side of the handshake pins
// ---------------------------------------------------------------
module umc_modem_model
(
   // Clock and answer speed
   input  wire logic ref_clk,
   input  wire logic slowAnswer,
   // Lines the bench asks the modem to raise
   input  wire logic ringOn,
   input  wire logic carrierOn,
   input  wire logic rxdLevel,
   // Handshakes from the port
   input  wire logic termReadyN,
   input  wire logic reqSendN,
   // Pins towards the port, handshakes active low, data as driven
   output logic      clearSendN,
   output logic      setReadyN,
   output logic      ringN,
   output logic      carrierN,
   output logic      rxdPin
);
   int waitCnt = 0;
   initial
   begin
      clearSendN = 1'b1;
      setReadyN  = 1'b1;
   end
   // Echo RTS on CTS and DTR on DSR, after 2 or 9 cycles
   always @(posedge ref_clk)
   begin
      if (clearSendN == reqSendN && setReadyN == termReadyN)
         waitCnt <= 0;
      else if (waitCnt < (slowAnswer ? 8 : 1))
         waitCnt <= waitCnt + 1;
      else
      begin
         clearSendN <= reqSendN;
         setReadyN  <= termReadyN;
      end
   end
   // Ring, carrier and data are driven as asked
   assign ringN    = ~ringOn;
   assign carrierN = ~carrierOn;
   assign rxdPin   = rxdLevel;
endmodule

// ==== bench/uart_modem_control_loopback_tb_top.sv ====
`timescale 1ns/1ps
module uart_modem_control_loopback_tb_top;
   import umc_pkg::*;
   logic        ref_clk = 0, nrst = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        txShiftOut = 1, rxTxIntReq = 0, slowAnswer = 0;
   logic        ringOn = 0, carrierOn = 0, rxdLevel = 1;
   logic        rxShiftIn, txdPin, rxdPin, termReadyN, reqSendN;
   logic        clearSendN, setReadyN, ringN, carrierN;
   logic        irqPinOut, irqPinOeN, irq;
   logic [31:0] rd;
   logic [1:0]  rsp;
   int          err_total = 0, total_checks = 0;
   logic [3:0]  lbMap [4] = '{4'h2, 4'h1, 4'h4, 4'h8};

   // Half period of 2 ns gives 250 MHz
   always #2 ref_clk = ~ref_clk;

   umc_modem_ctrl dut_u (.ref_clk(ref_clk), .nrst(nrst),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .txShiftOut(txShiftOut),
      .rxShiftIn(rxShiftIn), .rxTxIntReq(rxTxIntReq), .txdPin(txdPin),
      .rxdPin(rxdPin), .termReadyN(termReadyN), .reqSendN(reqSendN),
      .clearSendN(clearSendN), .setReadyN(setReadyN), .ringN(ringN),
      .carrierN(carrierN), .irqPinOut(irqPinOut),
      .irqPinOeN(irqPinOeN), .irq(irq));

   umc_modem_model modem_u (.ref_clk(ref_clk), .slowAnswer(slowAnswer),
      .ringOn(ringOn), .carrierOn(carrierOn), .rxdLevel(rxdLevel),
      .termReadyN(termReadyN), .reqSendN(reqSendN),
      .clearSendN(clearSendN), .setReadyN(setReadyN), .ringN(ringN),
      .carrierN(carrierN), .rxdPin(rxdPin));

   // ------------------------------------------------------------
   // Reporting
   // ------------------------------------------------------------
   task automatic final_report;
      $display("Checks %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chkWord(input logic [31:0] g, e, input string w);
      total_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, w, g, e);
      end
   endtask
   task automatic chkPin(input logic g, e, input string w);
      chkWord({31'h0, g}, {31'h0, e}, w);
   endtask
   // A hung handshake ends the run at once
   task automatic hung(input string w);
      err_total++;
      $display("CHECK FAILED t=%0t no answer on %s", $time, w);
      final_report;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // ------------------------------------------------------------
   // AXI4-Lite master
   // ------------------------------------------------------------
   task automatic axiWr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
      int n;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
            break;
      end
      if (n == 40)
         hung("write");
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic axiRd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
      int n;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
            break;
      end
      if (n == 40)
         hung("read");
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wrOk(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axiWr(a, d, r);
      chkWord({30'h0, r}, {30'h0, RESP_OKAY}, "bresp");
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] e,
                        input string w);
      logic [31:0] d;
      logic [1:0]  r;
      axiRd(a, d, r);
      chkWord(d, e, w);
      chkWord({30'h0, r}, {30'h0, RESP_OKAY}, "rresp");
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic testRegs;
      rdChk(HSCTL_OFF, 32'h0, "ctl reset");
      chkPin(irqPinOeN, 1'b1, "irq pin float");
      wrOk(HSCTL_OFF, 32'h1);
      tick(2);
      chkPin(termReadyN, 1'b0, "dtr on");
      chkPin(reqSendN, 1'b1, "rts off");
      wrOk(HSCTL_OFF, 32'h2);
      tick(2);
      chkPin(termReadyN, 1'b1, "dtr off");
      chkPin(reqSendN, 1'b0, "rts on");
      wrOk(HSCTL_OFF, 32'hFFFFFFE4);
      tick(2);
      rdChk(HSCTL_OFF, 32'h4, "spare only");
      chkPin(reqSendN, 1'b1, "spare no pin");
      wrOk(HSCTL_OFF, 32'h8);
      tick(2);
      chkPin(irqPinOeN, 1'b0, "irq pin driven");
      axiRd(8'h40, rd, rsp);
      chkWord({30'h0, rsp}, {30'h0, RESP_DECERR}, "unmapped read");
      chkWord(rd, 32'h0, "unmapped data");
      axiWr(8'h40, 32'h1, rsp);
      chkWord({30'h0, rsp}, {30'h0, RESP_DECERR}, "unmapped write");
      // Byte 0 strobe off and a write to the line readback change nothing
      s_axi_wstrb <= 4'hE;
      wrOk(HSCTL_OFF, 32'h1F);
      s_axi_wstrb <= 4'hF;
      wrOk(LINES_OFF, 32'hF);
      rdChk(HSCTL_OFF, 32'h8, "strobe off kept");
      // Slow modem answer to DTR and RTS, ring and carrier raised
      slowAnswer <= 1'b1;
      ringOn     <= 1'b1;
      carrierOn  <= 1'b1;
      wrOk(HSCTL_OFF, 32'h3);
      tick(16);
      rdChk(LINES_OFF, 32'hF, "normal lines");
      $display("test registers done");
   endtask

   task automatic testLoop;
      slowAnswer <= 1'b0;
      wrOk(HSCTL_OFF, 32'h13);
      tick(2);
      chkPin(termReadyN, 1'b1, "loop dtr pin");
      chkPin(reqSendN, 1'b1, "loop rts pin");
      rdChk(LINES_OFF, 32'h3, "pins ignored");
      txShiftOut <= 1'b0;
      tick(3);
      chkPin(txdPin, 1'b1, "txd mark");
      chkPin(rxShiftIn, 1'b0, "loop rx low");
      txShiftOut <= 1'b1;
      rxdLevel   <= 1'b0;
      tick(3);
      chkPin(rxShiftIn, 1'b1, "loop rx high");
      for (int b = 0; b < 4; b++)
      begin
         wrOk(HSCTL_OFF, 32'h10 | (32'h1 << b));
         tick(2);
         rdChk(LINES_OFF, {28'h0, lbMap[b]}, "loop map");
      end
      txShiftOut <= 1'b0;
      wrOk(HSCTL_OFF, 32'h0);
      tick(8);
      chkPin(rxShiftIn, 1'b0, "rx from pin");
      chkPin(txdPin, 1'b0, "txd follows");
      rdChk(LINES_OFF, 32'hC, "lines back");
      $display("test loopback done");
   endtask

   task automatic testIrq;
      wrOk(HSCTL_OFF, 32'h18);
      tick(4);
      wrOk(EVT_OFF, 32'hF);
      wrOk(MASK_OFF, 32'hF);
      rdChk(MASK_OFF, 32'hF, "mask rw");
      chkPin(irq, 1'b0, "irq quiet");
      wrOk(HSCTL_OFF, 32'h1A);
      tick(3);
      rdChk(EVT_OFF, 32'h1, "cts event");
      chkPin(irq, 1'b1, "irq raised");
      chkPin(irqPinOut, 1'b1, "irq pin high");
      wrOk(EVT_OFF, 32'h1);
      tick(2);
      chkPin(irq, 1'b0, "irq cleared");
      wrOk(MASK_OFF, 32'h0);
      wrOk(HSCTL_OFF, 32'h18);
      tick(3);
      rdChk(EVT_OFF, 32'h1, "masked event");
      chkPin(irq, 1'b0, "irq masked");
      rxTxIntReq <= 1'b1;
      tick(3);
      chkPin(irqPinOut, 1'b1, "rx tx irq");
      rxTxIntReq <= 1'b0;
      tick(3);
      chkPin(irqPinOut, 1'b0, "rx tx idle");
      wrOk(HSCTL_OFF, 32'h1F);
      tick(2);
      chkPin(irqPinOeN, 1'b0, "pin on");
      // Mid-run reset must clear every control bit
      nrst <= 1'b0;
      tick(4);
      nrst <= 1'b1;
      tick(1);
      rdChk(HSCTL_OFF, 32'h0, "ctl re-reset");
      chkPin(irqPinOeN, 1'b1, "pin float");
      $display("test interrupts done");
   endtask

   // Reset for 4 cycles, then the scenarios in turn
   initial
   begin
      tick(4);
      nrst <= 1'b1;
      testRegs;
      testLoop;
      testIrq;
      final_report;
   end
endmodule
